//--- design/cssc_top.sv
// The address map and the APB slave port were chosen for this implementation.
`include "cssc_cfg.svh"
module cssc_top (
	input  wire logic                   sys_clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   psel_i,
	input  wire logic                   penable_i,
	input  wire logic                   pwrite_i,
	input  wire logic            [11:0] paddr_i,
	input  wire logic            [31:0] pwdata_i,
	output logic                 [31:0] prdata_o,
	output logic                        pready_o,
	output logic                        pslverr_o,
	input  wire logic                   external_osc_ready_i,
	input  wire logic                   high_freq_internal_ready_i,
	input  wire logic                   mid_freq_internal_ready_i,
	input  wire logic                   low_freq_internal_ready_i,
	input  wire logic                   secondary_osc_ready_i,
	input  wire logic                   converter_osc_ready_i,
	input  wire logic                   pll_ready_i,
	output cssc_pkg::cssc_src_t         current_source_o,
	output cssc_pkg::cssc_div_t         current_divider_o,
	output logic                        secondary_osc_power_mode_o,
	output logic                        switch_held_o
);
	import cssc_pkg::*;

	localparam int SETTLE = `CSSC_SETTLE_CYC;

	cssc_state_t state_q;
	cssc_src_t   req_src_q;
	cssc_div_t   req_div_q;
	cssc_src_t   cur_src_q;
	cssc_div_t   cur_div_q;
	cssc_src_t   tgt_src_q;
	cssc_div_t   tgt_div_q;
	logic        done_q;
	logic        hold_q;
	logic        pwr_q;
	logic [7:0]  stat_q;
	logic [1:0]  settle_q;
	logic        sel_rdy;
	logic        wr_en;
	logic        rd_en;
	logic        switching;
	logic        new_rdy;
	logic        done;
	logic [7:0]  ctrl_rd;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// zero-wait slave: access phase always completes in its first cycle
	assign wr_en     = psel_i & penable_i & pwrite_i;
	assign rd_en     = psel_i & penable_i & ~pwrite_i;
	assign switching = (state_q != CSSC_IDLE);
	assign new_rdy   = switching & sel_rdy;
	assign done      = (cur_src_q == req_src_q) & (cur_div_q == req_div_q);

	// control readback; unimplemented bits tie low
	always_comb begin
		ctrl_rd                   = 8'h00;
		ctrl_rd[`CSSC_BIT_HOLD]   = hold_q;
		ctrl_rd[`CSSC_BIT_PWR]    = pwr_q;
		ctrl_rd[`CSSC_BIT_DONE]   = done_q;
		ctrl_rd[`CSSC_BIT_NRDY]   = new_rdy;
	end

	// ----------------------------------------
	// ready flag lookup for requested source
	// ----------------------------------------
	cssc_ready_sel cssc_ready_sel_i (
		.stat_i (stat_q),
		.src_i  (req_src_q),
		.rdy_o  (sel_rdy)
	);

	// status register samples oscillator ready inputs; bit 1 held low
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_q <= 8'h00;
		end else begin
			stat_q <= {external_osc_ready_i, high_freq_internal_ready_i,
				mid_freq_internal_ready_i, low_freq_internal_ready_i,
				secondary_osc_ready_i, converter_osc_ready_i, 1'b0,
				pll_ready_i};
		end
	end

	// complete flag is registered so that it reads zero out of reset
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done & ~switching;
		end
	end

	// request fields; reserved source codes drop the whole write
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_src_q <= `CSSC_RST_SRC;
			req_div_q <= `CSSC_RST_DIV;
		end else if (wr_en && paddr_i == `CSSC_ADDR_REQ &&
				pwdata_i[6:4] != `CSSC_RSV_SRC && pwdata_i[6:4] != `CSSC_RSV_SRC0) begin
			req_src_q <= pwdata_i[6:4];
			req_div_q <= pwdata_i[3:0];
		end
	end

	// power mode bit, software only
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwr_q <= 1'b0;
		end else if (wr_en && paddr_i == `CSSC_ADDR_CTRL) begin
			pwr_q <= pwdata_i[`CSSC_BIT_PWR];
		end
	end

	// hold bit; completion of a switch clears it and wins over software
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_q <= 1'b0;
		end else if (state_q == CSSC_SETTLE && settle_q == 2'd0) begin
			hold_q <= 1'b0;
		end else if (wr_en && paddr_i == `CSSC_ADDR_CTRL) begin
			hold_q <= pwdata_i[`CSSC_BIT_HOLD];
		end
	end

	// ----------------------------------------
	// switch sequencer
	// ----------------------------------------
	// a request changed mid-settle is taken up again from idle
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q   <= CSSC_IDLE;
			settle_q  <= 2'd0;
			cur_src_q <= `CSSC_RST_SRC;
			cur_div_q <= `CSSC_RST_DIV;
			tgt_src_q <= `CSSC_RST_SRC;
			tgt_div_q <= `CSSC_RST_DIV;
		end else begin
			case (state_q)
				CSSC_IDLE: begin
					if (!done) begin
						state_q <= CSSC_WAIT;
					end
				end
				CSSC_WAIT: begin
					if (sel_rdy && hold_q) begin
						state_q <= CSSC_HELD;
					end else if (sel_rdy) begin
						state_q  <= CSSC_SETTLE;
						settle_q <= 2'(SETTLE - 1);
						// latch the ready target; a later request must not slip in
						tgt_src_q <= req_src_q;
						tgt_div_q <= req_div_q;
					end
				end
				CSSC_HELD: begin
					if (!sel_rdy) begin
						state_q <= CSSC_WAIT;
					end else if (!hold_q) begin
						state_q  <= CSSC_SETTLE;
						settle_q <= 2'(SETTLE - 1);
						tgt_src_q <= req_src_q;
						tgt_div_q <= req_div_q;
					end
				end
				default: begin
					if (settle_q != 2'd0) begin
						settle_q <= settle_q - 2'd1;
					end else begin
						cur_src_q <= tgt_src_q;
						cur_div_q <= tgt_div_q;
						state_q   <= CSSC_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// registered outputs and bus answer
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o                   <= 32'h0000_0000;
			pready_o                   <= 1'b0;
			pslverr_o                  <= 1'b0;
			current_source_o           <= `CSSC_RST_SRC;
			current_divider_o          <= `CSSC_RST_DIV;
			secondary_osc_power_mode_o <= 1'b0;
			switch_held_o              <= 1'b0;
		end else begin
			current_source_o           <= cur_src_q;
			current_divider_o          <= cur_div_q;
			secondary_osc_power_mode_o <= pwr_q;
			switch_held_o              <= (state_q == CSSC_HELD);
			pready_o                   <= psel_i & ~penable_i;
			pslverr_o                  <= 1'b0;
			prdata_o                   <= 32'h0000_0000;
			if (psel_i && !penable_i && !pwrite_i) begin
				if (paddr_i == `CSSC_ADDR_CTRL) begin
					prdata_o <= {24'h00_0000, ctrl_rd};
				end else if (paddr_i == `CSSC_ADDR_STAT) begin
					prdata_o <= {24'h00_0000, stat_q};
				end else if (paddr_i == `CSSC_ADDR_REQ) begin
					prdata_o <= {25'h000_0000, req_src_q, req_div_q};
				end else if (paddr_i == `CSSC_ADDR_CUR) begin
					prdata_o <= {25'h000_0000, cur_src_q, cur_div_q};
				end else begin
					pslverr_o <= 1'b1;
				end
			end else if (psel_i && !penable_i) begin
				pslverr_o <= !(paddr_i == `CSSC_ADDR_CTRL || paddr_i == `CSSC_ADDR_STAT
					|| paddr_i == `CSSC_ADDR_REQ || paddr_i == `CSSC_ADDR_CUR);
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence held_s;
		state_q == CSSC_HELD;
	endsequence

	hold_stalls_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_q == CSSC_WAIT && sel_rdy && hold_q) |=> held_s)
		else $error("held switch did not stall");
	switch_goes_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_q == CSSC_WAIT && sel_rdy && !hold_q) |=> ##[0:4] (state_q == CSSC_IDLE))
		else $error("switch did not complete");
	power_out_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		##1 secondary_osc_power_mode_o == $past(pwr_q))
		else $error("power mode output wrong");
	done_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		switching |-> !ctrl_rd[`CSSC_BIT_DONE])
		else $error("complete flag set while switching");
	nrdy_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ctrl_rd[`CSSC_BIT_NRDY] |-> (switching && sel_rdy))
		else $error("new ready flag without cause");
	nrdy_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_q == CSSC_IDLE) |-> !ctrl_rd[`CSSC_BIT_NRDY])
		else $error("new ready flag while idle");
	unimpl_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(ctrl_rd[5] == 1'b0) && (ctrl_rd[2:0] == 3'h0))
		else $error("unimplemented bits nonzero");
	hold_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_q == CSSC_SETTLE && settle_q == 2'd0) |=> !hold_q)
		else $error("hold not cleared at completion");
	stat_bit1_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		stat_q[1] == 1'b0)
		else $error("status bit 1 nonzero");
endmodule

//--- design/cssc_cfg.svh
`ifndef CSSC_CFG_SVH
`define CSSC_CFG_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CSSC_ADDR_CTRL      12'h000
`define CSSC_ADDR_STAT      12'h004
`define CSSC_ADDR_REQ       12'h008
`define CSSC_ADDR_CUR       12'h00C
// ----------------------------------------
// control register fields
// ----------------------------------------
`define CSSC_BIT_HOLD       7
`define CSSC_BIT_PWR        6
`define CSSC_BIT_DONE       4
`define CSSC_BIT_NRDY       3
// ----------------------------------------
// status register fields and reserved source codes
// ----------------------------------------
`define CSSC_BIT_PLL        0
`define CSSC_RSV_SRC        3'h3
`define CSSC_RSV_SRC0       3'h0
// ----------------------------------------
// reset values
// ----------------------------------------
`define CSSC_RST_SRC        3'h6
`define CSSC_RST_DIV        4'h2
// ----------------------------------------
// timing: settle time of the switch mux
// ----------------------------------------
`define CSSC_SETTLE_NS      8
`define CSSC_CLK_NS         4
`define CSSC_SETTLE_CYC     ((`CSSC_SETTLE_NS + `CSSC_CLK_NS - 1) / `CSSC_CLK_NS)
`endif

//--- design/cssc_pkg.sv
package cssc_pkg;
	typedef enum logic [1:0] {
		CSSC_IDLE   = 2'b00,
		CSSC_WAIT   = 2'b01,
		CSSC_HELD   = 2'b10,
		CSSC_SETTLE = 2'b11
	} cssc_state_t;
	typedef logic [2:0] cssc_src_t;
	typedef logic [3:0] cssc_div_t;
endpackage

//--- design/cssc_ready_sel.sv
// ----------------------------------------
// picks the ready flag of the requested source
// ----------------------------------------
module cssc_ready_sel (
	input  wire logic              [7:0] stat_i,
	input  wire cssc_pkg::cssc_src_t     src_i,
	output logic                         rdy_o
);
	import cssc_pkg::*;
	// codes follow the source table; reserved codes never report ready
	always_comb begin
		case (src_i)
			3'h7:    rdy_o = stat_i[7];
			3'h6:    rdy_o = stat_i[6];
			3'h5:    rdy_o = stat_i[4];
			3'h4:    rdy_o = stat_i[3];
			3'h2:    rdy_o = stat_i[7] & stat_i[0];
			3'h1:    rdy_o = stat_i[6] & stat_i[0];
			default: rdy_o = 1'b0;
		endcase
	end
endmodule

//--- tb/tb_cssc_top.sv
`include "cssc_cfg.svh"
module tb_cssc_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cssc_pkg::*;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic                sys_clk_i = 1'b0;
	logic                rst_n_i   = 1'b0;
	logic                psel_i    = 1'b0;
	logic                penable_i = 1'b0;
	logic                pwrite_i  = 1'b0;
	logic         [11:0] paddr_i   = 12'h000;
	logic         [31:0] pwdata_i  = 32'h0000_0000;
	logic         [31:0] prdata_o;
	logic                pready_o;
	logic                pslverr_o;
	logic          [6:0] rdy       = 7'h00; // ext,hf,mid,low,sosc,conv,pll
	cssc_src_t           current_source_o;
	cssc_div_t           current_divider_o;
	logic                secondary_osc_power_mode_o;
	logic                switch_held_o;
	logic         [31:0] rd;
	logic                err;
	int                  bad_count = 0;
	int                  n_tests   = 0;
	// 250 MHz
	always #2 sys_clk_i = ~sys_clk_i;
	cssc_top cssc_top_i (
		.sys_clk_i                  (sys_clk_i),
		.rst_n_i                    (rst_n_i),
		.psel_i                     (psel_i),
		.penable_i                  (penable_i),
		.pwrite_i                   (pwrite_i),
		.paddr_i                    (paddr_i),
		.pwdata_i                   (pwdata_i),
		.prdata_o                   (prdata_o),
		.pready_o                   (pready_o),
		.pslverr_o                  (pslverr_o),
		.external_osc_ready_i       (rdy[6]),
		.high_freq_internal_ready_i (rdy[5]),
		.mid_freq_internal_ready_i  (rdy[4]),
		.low_freq_internal_ready_i  (rdy[3]),
		.secondary_osc_ready_i      (rdy[2]),
		.converter_osc_ready_i      (rdy[1]),
		.pll_ready_i                (rdy[0]),
		.current_source_o           (current_source_o),
		.current_divider_o          (current_divider_o),
		.secondary_osc_power_mode_o (secondary_osc_power_mode_o),
		.switch_held_o              (switch_held_o)
	);
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		psel_i   <= 1'b1;
		pwrite_i <= wr;
		paddr_i  <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			@(posedge sys_clk_i);
			if (pready_o === 1'b1) begin
				rd = prdata_o;
				err = pslverr_o;
				psel_i    <= 1'b0;
				penable_i <= 1'b0;
				return;
			end
		end
		chk(32'hDEAD, 32'h0);
		tally_and_finish();
	endtask
	// bounded wait for the held flag or for a given current source
	task automatic wait_for(input logic held, input cssc_src_t s);
		for (int i = 0; i < 64; i++) begin
			@(posedge sys_clk_i);
			if (held ? (switch_held_o === 1'b1) : (current_source_o === s)) begin
				return;
			end
		end
		chk(32'hBAD, 32'h0);
		tally_and_finish();
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk(secondary_osc_power_mode_o, 0);
		chk(switch_held_o, 0);
		apb(0, `CSSC_ADDR_CTRL, 0);
		chk(rd & 32'hEF, 32'h0);
		apb(0, `CSSC_ADDR_CUR, 0);
		chk(rd, 32'h62);
		$display("test reset done");
	endtask
	// loose bits must stay zero even when all ones are written
	task automatic t_ctrl();
		apb(1, `CSSC_ADDR_CTRL, 32'hFFFF_FFFF);
		apb(0, `CSSC_ADDR_CTRL, 0);
		chk(rd & 32'hEF, 32'hC0);
		chk(secondary_osc_power_mode_o, 1);
		apb(1, `CSSC_ADDR_CTRL, 0);
		// the output lags the committing edge by one register
		repeat (2) @(posedge sys_clk_i);
		chk(secondary_osc_power_mode_o, 0);
		$display("test control done");
	endtask
	task automatic t_stat();
		logic [6:0] pat [2] = '{7'h55, 7'h2A};
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk_i);
			rdy <= pat[k];
			repeat (2) @(posedge sys_clk_i);
			apb(1, `CSSC_ADDR_STAT, 32'hFF);
			apb(0, `CSSC_ADDR_STAT, 0);
			chk(rd, {24'h0, pat[k][6:1], 1'b0, pat[k][0]});
		end
		@(posedge sys_clk_i);
		rdy <= 7'h00;
		$display("test status done");
	endtask
	task automatic t_switch();
		apb(1, `CSSC_ADDR_REQ, 32'h51);
		apb(0, `CSSC_ADDR_CTRL, 0);
		chk(rd & 32'h18, 32'h0);
		rdy[3] <= 1'b1;
		wait_for(0, 3'h5);
		chk(current_divider_o, 1);
		apb(0, `CSSC_ADDR_CTRL, 0);
		chk(rd & 32'h18, 32'h10);
		$display("test switch done");
	endtask
	// a held switch must leave the old source running
	task automatic t_hold();
		apb(1, `CSSC_ADDR_CTRL, 32'h80);
		apb(1, `CSSC_ADDR_REQ, 32'h40);
		rdy[2] <= 1'b1;
		wait_for(1, 3'h0);
		apb(0, `CSSC_ADDR_CTRL, 0);
		chk(rd & 32'h98, 32'h88);
		chk(current_source_o, 5);
		apb(1, `CSSC_ADDR_CTRL, 0);
		wait_for(0, 3'h4);
		chk(switch_held_o, 0);
		apb(0, `CSSC_ADDR_CTRL, 0);
		chk(rd & 32'h98, 32'h10);
		// hold written while the switch settles is dropped by its completion
		apb(1, `CSSC_ADDR_REQ, 32'h51);
		apb(1, `CSSC_ADDR_CTRL, 32'h80);
		wait_for(0, 3'h5);
		apb(0, `CSSC_ADDR_CTRL, 0);
		chk(rd & 32'h98, 32'h10);
		$display("test hold done");
	endtask
	task automatic t_refuse();
		apb(1, `CSSC_ADDR_REQ, 32'h35);
		apb(0, `CSSC_ADDR_REQ, 0);
		chk(rd, 32'h51);
		apb(1, `CSSC_ADDR_CUR, 32'h11);
		apb(0, `CSSC_ADDR_CUR, 0);
		chk(rd, 32'h51);
		apb(0, 12'h010, 0);
		chk(err, 1);
		chk(current_source_o, 5);
		$display("test refuse done");
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_ctrl();
		t_stat();
		t_switch();
		t_hold();
		t_refuse();
		tally_and_finish();
	end
endmodule
